// >>> inc/safecp_consts.vh
// Purpose: Constants of the serial configuration port of the sensor front end.
// Assumes: Included by bare name from the design files.
// Notes: Register addresses, field positions, reset values and key bytes.
`ifndef SAFECP_CONSTS_VH
`define SAFECP_CONSTS_VH
`define SAFECP_ADDR_CONFIG 4'h0
`define SAFECP_ADDR_DAC 4'h1
`define SAFECP_ADDR_UNLOCK 4'hf
`define SAFECP_CONFIG_RESET 8'h00
`define SAFECP_DAC_RESET 8'h80
`define SAFECP_KEY_FIRST 8'hfe
`define SAFECP_KEY_SECOND 8'hed
`define SAFECP_INSTR_RW_BIT 7
`define SAFECP_INSTR_ADDR_HI 3
`define SAFECP_CFG_RSVD_BIT 7
`define SAFECP_CFG_PWR_HI 6
`define SAFECP_CFG_PWR_LO 5
`define SAFECP_CFG_FILT_BIT 4
`define SAFECP_CFG_BIAS_BIT 3
`define SAFECP_CFG_SECOND_STAGE_GAIN_HI 2
`define SAFECP_CFG_SECOND_STAGE_GAIN_LO 1
`define SAFECP_CFG_FIRST_STAGE_GAIN_BIT 0
`define SAFECP_BITS_PER_BYTE 4'h8
`define SAFECP_LAST_BIT 4'h7
`endif

// >>> verilog/safecp_sync.v
// Purpose: Three-stage synchroniser for the serial port pins.
// Assumes: Inputs are asynchronous to mclk.
// Notes: A level is accepted only when the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none
module safecp_sync (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Raw pin level, its reset level and its filtered copy
  input wire pin_in,
  input wire reset_level,
  output reg level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // The first stage feeds only the second, to keep metastability contained.
  always @(posedge mclk) begin
    if (sys_rst) begin
      s1_q <= reset_level;
      s2_q <= reset_level;
      s3_q <= reset_level;
      level_q <= reset_level;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/safecp_port.v
// Purpose: Serial configuration port and register bank of a sensor front end.
// Assumes: mclk at 100 MHz, serial clock at most a few MHz, pins asynchronous.
// Notes: The serial clock is sampled; its edges are found in the mclk domain.
//   Settings change only on a complete write; select edges reset the engine alone.
// Functional notes
// - After reset only writes are accepted; readback stays locked until the key.
// - Releasing select aborts a transaction; partial bytes have no effect.
// - Asserting select returns the serial engine to idle, awaiting an instruction.
// - Select may stay low; transactions are framed by counting clock edges.
// - Each transaction is one instruction byte and one data byte, no bursts.
// - Unlocked reads drive register data only during the data byte.
// - Instruction bit 7 is read or write, bits 3:0 address, 6:4 zero.
// - Every register is eight bits at its own unique 4-bit address.
// - Config and DAC readable only when unlocked; unlock register write-only.
// - Config bits 6:5 set stage power, reset both off; bit 7 reads zero.
// - Config bit 4 routes stage one through the external filter when set.
// - Config bits 2:1 set second stage gain, bit 0 first stage gain.
// - DAC code resets to 0x80, giving zero output shift.
// - Writing 0xfe then 0xed to the unlock register enables readback.
// - Any other unlock register write returns the port to write-only.
// - Data line is sampled on the rising serial clock edge.
// - Read data driven from the ninth falling edge, released after last rise.
`timescale 1ns/1ns
`default_nettype none
`include "safecp_consts.vh"
module safecp_port (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Serial pins
  input wire select_bar_line,
  input wire sclk,
  input wire sdio_in,
  output reg sdio_out,
  output reg sdio_oe,
  // Analog control outputs
  output reg [1:0] stage_power_q,
  output reg filter_route_bit,
  output reg bias_level_select,
  output reg [1:0] second_stage_gain,
  output reg first_stage_gain,
  output reg [7:0] offset_dac_code,
  output reg readback_unlocked
);
  // One-hot engine states.
  // ST_IGNORE is a spare code; if it is ever reached it falls back to ST_INSTR.
  localparam [2:0] ST_INSTR = 3'b001;
  localparam [2:0] ST_DATA = 3'b010;
  localparam [2:0] ST_IGNORE = 3'b100;

  // Synchronised pin copies; nothing below reads a raw pin.
  wire sel_n_s;
  wire sclk_s;
  wire sdio_s;
  // Edge history and serial engine state.
  reg sel_n_prev_q;
  reg sclk_prev_q;
  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] instr_q;
  // Register bank and read path.
  reg [7:0] config_q;
  reg [7:0] dac_q;
  reg key_half_q;
  reg unlock_q;
  reg [7:0] rd_shift_q;
  reg driving_q;

  // Register contents as seen by a read; bit 7 of config reads as zero.
  function [7:0] read_mux;
    input [3:0] addr;
    input [7:0] cfg;
    input [7:0] dac;
    begin
      if (addr == `SAFECP_ADDR_CONFIG) begin
        read_mux = cfg;
      end else if (addr == `SAFECP_ADDR_DAC) begin
        read_mux = dac;
      end else begin
        read_mux = 8'h00;
      end
    end
  endfunction

  // Readback gate. The unlock register never answers, so its key cannot be
  // fished back out of the port once written.
  function read_allowed;
    input [3:0] addr;
    input unlocked;
    begin
      read_allowed = unlocked && (addr != `SAFECP_ADDR_UNLOCK);
    end
  endfunction

  // Select idles high, so its stages reset high to avoid a false frame.
  safecp_sync u_sync_sel (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(select_bar_line),
    .reset_level(1'b1),
    .level_q(sel_n_s)
  );
  // The clock is parked high for reads, so a high reset level keeps edges quiet.
  safecp_sync u_sync_sclk (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(sclk),
    .reset_level(1'b1),
    .level_q(sclk_s)
  );
  // Data passes the same three stages as the clock, so the two stay aligned.
  safecp_sync u_sync_sdio (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(sdio_in),
    .reset_level(1'b0),
    .level_q(sdio_s)
  );

  // Edge and frame decode, all taken from the synchronised pin copies.
  // Each strobe below lasts exactly one mclk cycle.
  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire sclk_fall = ~sclk_s & sclk_prev_q;
  wire sel_fall = ~sel_n_s & sel_n_prev_q;
  // A frame is live while select is low now and was low a cycle ago as well.
  wire frame_live = ~sel_n_s & ~sel_fall;
  wire [7:0] byte_in = {shift_q[6:0], sdio_s};
  wire byte_done = (bit_cnt_q == `SAFECP_LAST_BIT);
  wire [3:0] instr_addr = instr_q[`SAFECP_INSTR_ADDR_HI:0];
  wire is_read = instr_q[`SAFECP_INSTR_RW_BIT];
  // The last data rise of a write is the only moment a setting may change.
  wire wr_fire = frame_live & sclk_rise & (state_q == ST_DATA) & byte_done & ~is_read;
  // The first fall inside a read's data byte may start the drive.
  // Starting on the fall, not the rise, puts the first bit ahead of the ninth rise.
  wire rd_start = frame_live & sclk_fall & (state_q == ST_DATA) & (bit_cnt_q == 4'h0) &
    is_read & ~driving_q;

  // Serial engine: edge history, bit counter and instruction capture.
  // It never touches the register bank, so an aborted frame leaves settings alone.
  always @(posedge mclk) begin
    if (sys_rst) begin
      sel_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b1;
      state_q <= ST_INSTR;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      instr_q <= 8'h00;
    end else begin
      sel_n_prev_q <= sel_n_s;
      sclk_prev_q <= sclk_s;
      if (sel_n_s) begin
        state_q <= ST_INSTR;
        bit_cnt_q <= 4'h0;
      end else if (sel_fall) begin
        state_q <= ST_INSTR;
        bit_cnt_q <= 4'h0;
      end else if (sclk_rise) begin
        shift_q <= byte_in;
        bit_cnt_q <= byte_done ? 4'h0 : bit_cnt_q + 4'h1;
        case (state_q)
          ST_INSTR: begin
            if (byte_done) begin
              instr_q <= byte_in;
              state_q <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (byte_done) begin
              // one data byte then next instruction
              state_q <= ST_INSTR;
            end
          end
          ST_IGNORE: begin
            state_q <= ST_INSTR;
          end
          default: begin
            state_q <= ST_INSTR;
          end
        endcase
      end
    end
  end

  // Read path. The drive flag drops on any select edge as well as on the last data
  // rise, so a master that gives up mid-byte never meets a stuck driver.
  always @(posedge mclk) begin
    if (sys_rst) begin
      rd_shift_q <= 8'h00;
      driving_q <= 1'b0;
    end else if (~frame_live) begin
      driving_q <= 1'b0;
    end else if (rd_start) begin
      if (read_allowed(instr_addr, unlock_q)) begin
        driving_q <= 1'b1;
        rd_shift_q <= read_mux(instr_addr, config_q, dac_q);
      end
    end else if (sclk_rise && driving_q) begin
      rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      if (byte_done) begin
        driving_q <= 1'b0;
      end
    end
  end

  // Register bank. Only the write strobe opens it, which costs a wider decode but
  // keeps every partial or refused frame away from the stored settings.
  always @(posedge mclk) begin
    if (sys_rst) begin
      config_q <= `SAFECP_CONFIG_RESET;
      dac_q <= `SAFECP_DAC_RESET;
      key_half_q <= 1'b0;
      unlock_q <= 1'b0;
    end else if (wr_fire) begin
      case (instr_addr)
        `SAFECP_ADDR_CONFIG: begin
          config_q <= {1'b0, byte_in[`SAFECP_CFG_PWR_HI:0]};
        end
        `SAFECP_ADDR_DAC: begin
          dac_q <= byte_in;
        end
        `SAFECP_ADDR_UNLOCK: begin
          if (key_half_q && byte_in == `SAFECP_KEY_SECOND) begin
            unlock_q <= 1'b1;
            key_half_q <= 1'b0;
          end else if (byte_in == `SAFECP_KEY_FIRST) begin
            unlock_q <= 1'b0;
            key_half_q <= 1'b1;
          end else begin
            unlock_q <= 1'b0;
            key_half_q <= 1'b0;
          end
        end
        default: begin
          // Other addresses are ignored and leave the key state as it was.
          key_half_q <= key_half_q;
        end
      endcase
    end
  end

  // Pin drivers. The enable also looks at select itself, so a released frame frees
  // the line in the same cycle that the read path drops its own flag.
  always @(posedge mclk) begin
    if (sys_rst) begin
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
    end else begin
      sdio_oe <= driving_q & ~sel_n_s;
      sdio_out <= rd_shift_q[7];
    end
  end

  // Analog control registers, so every control line leaves a flip-flop.
  always @(posedge mclk) begin
    if (sys_rst) begin
      stage_power_q <= 2'b00;
      filter_route_bit <= 1'b0;
      bias_level_select <= 1'b0;
      second_stage_gain <= 2'b00;
      first_stage_gain <= 1'b0;
      offset_dac_code <= `SAFECP_DAC_RESET;
      readback_unlocked <= 1'b0;
    end else begin
      stage_power_q <= config_q[`SAFECP_CFG_PWR_HI:`SAFECP_CFG_PWR_LO];
      filter_route_bit <= config_q[`SAFECP_CFG_FILT_BIT];
      bias_level_select <= config_q[`SAFECP_CFG_BIAS_BIT];
      second_stage_gain <= config_q[`SAFECP_CFG_SECOND_STAGE_GAIN_HI:`SAFECP_CFG_SECOND_STAGE_GAIN_LO];
      first_stage_gain <= config_q[`SAFECP_CFG_FIRST_STAGE_GAIN_BIT];
      offset_dac_code <= dac_q;
      readback_unlocked <= unlock_q;
    end
  end
endmodule
`default_nettype wire

// >>> verification/safecp_port_properties.sv
// Purpose: Checker of the serial port's pin and register timing.
// Assumes: Sees only the ports of safecp_port; mclk domain, sys_rst reset.
// Notes: Pins are asynchronous, so bounds allow for the sync stages.
`timescale 1ns/1ns
`default_nettype none
module safecp_port_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic select_bar_line,
  input wire logic sclk,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  // Analog controls
  input wire logic [1:0] stage_power_q,
  input wire logic filter_route_bit,
  input wire logic bias_level_select,
  input wire logic [1:0] second_stage_gain,
  input wire logic first_stage_gain,
  input wire logic [7:0] offset_dac_code,
  input wire logic readback_unlocked
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Drive start is a rise of the enable inside a selected frame.
  sequence s_drive_start; $rose(sdio_oe) ##0 !select_bar_line; endsequence
  property p_oe_lock; sdio_oe |-> readback_unlocked; endproperty
  a_oe_lock: assert property (p_oe_lock) else $error("drive while locked");
  property p_oe_idle; select_bar_line [*8] |-> !sdio_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("drive while idle");
  property p_abort; $rose(select_bar_line) |-> ##[0:8] !sdio_oe; endproperty
  a_abort: assert property (p_abort) else $error("drive kept after select");
  property p_oe_start; s_drive_start |-> !$past(sclk, 4); endproperty
  a_oe_start: assert property (p_oe_start) else $error("drive not after fall");
  property p_oe_end; $fell(sdio_oe) |-> $past(sclk, 2) || $past(select_bar_line, 2); endproperty
  a_oe_end: assert property (p_oe_end) else $error("early release");
  property p_shift; sdio_oe && $past(sdio_oe) && $changed(sdio_out) |-> $past(sclk, 2); endproperty
  a_shift: assert property (p_shift) else $error("bit moved off rise");
  property p_upd;
    $changed({stage_power_q, filter_route_bit, bias_level_select, second_stage_gain,
      first_stage_gain, offset_dac_code}) |-> !select_bar_line;
  endproperty
  a_upd: assert property (p_upd) else $error("update outside frame");
  property p_mode; $changed(readback_unlocked) |-> !select_bar_line && !sdio_oe; endproperty
  a_mode: assert property (p_mode) else $error("mode change off write");
endmodule
bind safecp_port safecp_port_properties safecp_port_properties_i (
  .mclk(mclk), .sys_rst(sys_rst), .select_bar_line(select_bar_line), .sclk(sclk),
  .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .stage_power_q(stage_power_q),
  .filter_route_bit(filter_route_bit), .bias_level_select(bias_level_select),
  .second_stage_gain(second_stage_gain), .first_stage_gain(first_stage_gain),
  .offset_dac_code(offset_dac_code), .readback_unlocked(readback_unlocked));
`default_nettype wire

// >>> verification/safecp_master.sv
// Purpose: Serial master model for the configuration port.
// Assumes: Link clock period 125 ns, parked high between frames.
// Notes: A released data line flips every mclk so stale bits never match.
`timescale 1ns/1ns
`default_nettype none
module safecp_master (
  // Filler clock
  input wire logic mclk,
  // Device side of the data line
  input wire logic sdio_out,
  input wire logic sdio_oe,
  // Master pins
  output logic select_bar_line,
  output logic sclk,
  output logic sdio_in
);
  logic drv = 1'b0;
  logic rel = 1'b0;
  logic fill = 1'b0;
  // Wire level from both parties.
  always @(posedge mclk) fill <= ~fill;
  assign sdio_in = sdio_oe ? sdio_out : (rel ? fill : drv);
  initial begin
    select_bar_line = 1'b1;
    sclk = 1'b1;
  end
  task automatic xfer(input logic [7:0] ins, input logic [7:0] dat, input int nb,
      input logic hold, output logic [7:0] rd, output logic seen);
    seen = 1'b0;
    select_bar_line = 1'b0;
    #100;
    for (int i = 0; i < nb; i++) begin
      sclk = 1'b0;
      rel = ins[7] && i > 7;
      drv = (i < 8) ? ins[7 - i] : dat[15 - i];
      #62;
      sclk = 1'b1;
      #20;
      rd = {rd[6:0], sdio_in};
      seen = seen | sdio_oe;
      #43;
    end
    rel = 1'b0;
    #100;
    select_bar_line = ~hold;
    #200;
  endtask
endmodule
`default_nettype wire

// >>> verification/safecp_port_bench.sv
// Purpose: Self-checking bench of the serial configuration port.
// Assumes: mclk 100 MHz; the master model makes the 125 ns link clock.
// Notes: Expected values follow the register map, never the outputs.
`timescale 1ns/1ns
`default_nettype none
module safecp_port_bench;
  logic mclk, sys_rst, select_bar_line, sclk, sdio_in, sdio_out, sdio_oe, seen;
  logic [1:0] stage_power_q, second_stage_gain;
  logic filter_route_bit, bias_level_select, first_stage_gain, readback_unlocked;
  logic [7:0] offset_dac_code, rd, cfg_w;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  assign cfg_w = {1'b0, stage_power_q, filter_route_bit, bias_level_select,
    second_stage_gain, first_stage_gain};
  safecp_port safecp_port_i (.mclk(mclk), .sys_rst(sys_rst),
    .select_bar_line(select_bar_line), .sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .stage_power_q(stage_power_q), .filter_route_bit(filter_route_bit),
    .bias_level_select(bias_level_select), .second_stage_gain(second_stage_gain),
    .first_stage_gain(first_stage_gain), .offset_dac_code(offset_dac_code),
    .readback_unlocked(readback_unlocked));
  safecp_master safecp_master_i (.mclk(mclk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .select_bar_line(select_bar_line), .sclk(sclk), .sdio_in(sdio_in));
  // System clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Compare and count.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write, possibly cut short or kept selected.
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input int nb = 16,
      input logic hold = 1'b0);
    safecp_master_i.xfer({4'h0, a}, d, nb, hold, rd, seen);
  endtask
  // Read; a refused read must leave the line undriven.
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input logic drive);
    safecp_master_i.xfer({4'h8, a}, 8'h00, 16, 1'b0, rd, seen);
    chk({7'h0, seen}, {7'h0, drive});
    if (drive)
      chk(rd, exp);
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Ceiling well above the roughly 5000 cycles the sequence needs.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // Main sequence.
  initial begin
    sys_rst = 1'b1;
    repeat (16) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    chk(cfg_w, 8'h00);
    chk(offset_dac_code, 8'h80);
    chk({7'h0, readback_unlocked}, 8'h00);
    rdc(4'h1, 8'h80, 1'b0);
    wr(4'h0, 8'hff);
    chk(cfg_w, 8'h7f);
    wr(4'h0, 8'h15);
    chk(cfg_w, 8'h15);
    wr(4'h0, 8'h0a);
    chk(cfg_w, 8'h0a);
    for (int k = 0; k < 4; k++) begin
      wr(4'h0, {1'b0, k[1:0], 2'h0, k[1:0], 1'b0});
      chk({6'h0, stage_power_q}, k[7:0]);
      chk({6'h0, second_stage_gain}, k[7:0]);
    end
    wr(4'h1, 8'h55);
    wr(4'h1, 8'haa, 12);
    wr(4'h5, 8'h3c);
    chk(offset_dac_code, 8'h55);
    chk(cfg_w, 8'h66);
    wr(4'hf, 8'hfe);
    wr(4'hf, 8'hed);
    chk({7'h0, readback_unlocked}, 8'h01);
    rdc(4'h1, 8'h55, 1'b1);
    rdc(4'h0, 8'h66, 1'b1);
    rdc(4'hf, 8'h00, 1'b0);
    wr(4'h1, 8'h12, 16, 1'b1);
    chk(offset_dac_code, 8'h12);
    wr(4'h1, 8'h34);
    chk(offset_dac_code, 8'h34);
    wr(4'hf, 8'hfe);
    wr(4'hf, 8'h00);
    chk({7'h0, readback_unlocked}, 8'h00);
    rdc(4'h1, 8'h34, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
